// >>> common/mpm_pkg.sv
package mpm_pkg;

  // access sequencer states
  typedef enum logic [2:0] {
    MPM_IDLE,
    MPM_ADDR_LO,
    MPM_ADDR_LO_HOLD,
    MPM_ADDR_HI,
    MPM_ADDR_HI_HOLD,
    MPM_SETUP,
    MPM_STROBE,
    MPM_HOLD
  } mpm_state_type;

  // address step after each access
  localparam logic [1:0] MPM_STEP_NONE = 2'h0;
  localparam logic [1:0] MPM_STEP_INC  = 2'h1;
  localparam logic [1:0] MPM_STEP_DEC  = 2'h2;

  // address register field positions
  localparam int MPM_CS2_BIT    = 15;
  localparam int MPM_CS1_BIT    = 14;
  localparam int MPM_ADDR_W     = 16;
  localparam int MPM_DATA_W     = 8;

  // shortest phase lengths in clock cycles; strobe base covers the
  // two-flop delay on the returning read data
  localparam int MPM_SETUP_BASE  = 1;
  localparam int MPM_STROBE_BASE = 3;
  localparam int MPM_HOLD_BASE   = 1;
  localparam int MPM_TMR_W       = 5;

  // reset values
  localparam logic [15:0] MPM_ADDR_RST = 16'h0000;
  localparam logic [7:0]  MPM_DATA_RST = 8'h00;

endpackage : mpm_pkg

// >>> logic/mpm_wait_timer.sv
`timescale 1ns/10ps

// down counter that times the setup, strobe and hold phases
module mpm_wait_timer
  import mpm_pkg::*;
#(
  parameter int TMR_W = MPM_TMR_W
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             clk_en,
  input  wire logic             load,
  input  wire logic [TMR_W-1:0] load_value,
  output logic                  expired
);

  logic [TMR_W-1:0] count_reg;

  // refuse a counter too narrow for the longest strobe phase
  if (TMR_W < 5) begin : g_tmr_w_check
    $error("mpm_wait_timer: TMR_W too small for strobe");
  end

  // load wins over counting so a new phase never inherits old time
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
    end else if (clk_en) begin
      if (load) begin
        count_reg <= load_value;
      end else if (count_reg != '0) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  assign expired = (count_reg == '0);

endmodule : mpm_wait_timer

// >>> logic/mpm_addr_step.sv
`timescale 1ns/10ps

// next held address; select bits are never touched by the step
module mpm_addr_step
  import mpm_pkg::*;
(
  input  wire logic [15:0] addr_in,
  input  wire logic [1:0]  step_mode,
  input  wire logic        two_devices,
  output logic [15:0]      addr_out
);

  // wrap stays inside the address field of the active setup
  always_comb begin
    addr_out = addr_in;
    if (two_devices) begin
      if (step_mode == MPM_STEP_INC) begin
        addr_out = {addr_in[15:14], addr_in[13:0] + 14'h0001};
      end else if (step_mode == MPM_STEP_DEC) begin
        addr_out = {addr_in[15:14], addr_in[13:0] - 14'h0001};
      end
    end else begin
      if (step_mode == MPM_STEP_INC) begin
        addr_out = {addr_in[15], addr_in[14:0] + 15'h0001};
      end else if (step_mode == MPM_STEP_DEC) begin
        addr_out = {addr_in[15], addr_in[14:0] - 15'h0001};
      end
    end
  end

endmodule : mpm_addr_step

// >>> logic/mpm_master.sv
`timescale 1ns/10ps

// Overview of operation
// [R1] Low then high address byte, then data, all on the shared pins.
// [R2] Lowest address pin becomes the low-byte latch strobe.
// [R3] Second address pin becomes the high-byte latch strobe.
// [R4] The thirteen upper address pins are released, never driven.
// [R5] Each access runs low address, high address, then data phase.
// [R6] Both latch strobes are active high.
// [R7] Single device: chip select one carries address bit 14.
// [R8] Single device: bit 15 enables select two, bits 14..0 address.
// [R9] Two devices: both selects used, fourteen address bits remain.
// [R10] Two devices: bit 15 select two, bit 14 select one, 13..0 address.
// [R11] Only the addressed device's select goes active, same timing.
// [R12] Selects, read strobe and write strobe are active low.
// [R13] Byte-wide master with separate read and write strobes.
// [R14] Held address steps up, down or stays after each access.
// [R15] Optional interrupt pulse at completion of each access.
// [R16] Setup, strobe width and hold each set in wait cycles.
// [R17] Byte select output disabled; its polarity has no effect.
// [R18] Busy set from start until the data phase ends.
// [R19] External latches hold the address through the data phase.
module mpm_master
  import mpm_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        port_enable,
  input  wire logic        two_devices,
  input  wire logic [1:0]  step_mode,
  input  wire logic        irq_enable,
  input  wire logic [1:0]  wait_setup,
  input  wire logic [3:0]  wait_strobe,
  input  wire logic [1:0]  wait_hold,
  input  wire logic        addr_load,
  input  wire logic [15:0] addr_load_value,
  input  wire logic        start_read,
  input  wire logic        start_write,
  input  wire logic [7:0]  write_data,
  output logic [15:0]      access_address,
  output logic [7:0]       read_data,
  output logic             busy,
  output logic             done,
  output logic             irq,
  input  wire logic [7:0]  shared_addr_data_pins_in,
  output logic [7:0]       shared_addr_data_pins_out,
  output logic             shared_addr_data_pins_oe,
  output logic             low_addr_latch_strobe,
  output logic             high_addr_latch_strobe,
  output logic             chip_select_one_n,
  output logic             chip_select_two_n,
  output logic             read_strobe_out_n,
  output logic             write_strobe_out_n,
  output logic             byte_select_out,
  output logic             byte_select_out_oe,
  output logic [14:2]      port_address_pins_out,
  output logic [14:2]      port_address_pins_oe
);

  //////////////////////////////////////////////////////////////////////
  // declarations

  mpm_state_type          state_reg;
  mpm_state_type          state_next;
  logic [15:0]            addr_reg;
  logic [15:0]            addr_stepped;
  logic [7:0]             wdata_reg;
  logic [7:0]             rdata_reg;
  logic                   is_read_reg;
  logic                   busy_reg;
  logic                   done_reg;
  logic                   irq_reg;
  logic [7:0]             pin_meta_reg;
  logic [7:0]             pin_sync_reg;
  logic [7:0]             pd_out_reg;
  logic                   pd_oe_reg;
  logic                   lo_latch_reg;
  logic                   hi_latch_reg;
  logic                   cs1_n_reg;
  logic                   cs2_n_reg;
  logic                   rd_n_reg;
  logic                   wr_n_reg;
  logic                   go;
  logic                   finish;
  logic                   tmr_load;
  logic [MPM_TMR_W-1:0]   tmr_value;
  logic                   tmr_expired;
  logic                   data_phase;
  logic                   read_next;

  // phase length minus one, as the timer counts down to zero
  function automatic logic [MPM_TMR_W-1:0] phase_load(
    input logic [3:0] waits,
    input int         base
  );
    phase_load = MPM_TMR_W'({1'b0, waits} + 5'(base) - 5'h01);
  endfunction : phase_load

  //////////////////////////////////////////////////////////////////////
  // helpers

  // a new access only starts from idle; other starts are dropped
  assign go     = port_enable && (state_reg == MPM_IDLE) &&
                  (start_read || start_write);
  assign finish = (state_reg == MPM_HOLD) && tmr_expired;
  // read wins when both starts arrive together
  assign read_next = go ? start_read : is_read_reg;

  mpm_wait_timer #(
    .TMR_W      (MPM_TMR_W)
  ) u_timer (
    .clock      (clock),
    .rst        (rst),
    .clk_en     (clk_en),
    .load       (tmr_load),
    .load_value (tmr_value),
    .expired    (tmr_expired)
  );

  mpm_addr_step u_step (
    .addr_in     (addr_reg),
    .step_mode   (step_mode),
    .two_devices (two_devices),
    .addr_out    (addr_stepped)
  );

  //////////////////////////////////////////////////////////////////////
  // sequencer: two address phases, then the timed data phase

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      MPM_IDLE:         if (go) state_next = MPM_ADDR_LO; // R5
      MPM_ADDR_LO:      state_next = MPM_ADDR_LO_HOLD;
      MPM_ADDR_LO_HOLD: state_next = MPM_ADDR_HI;
      MPM_ADDR_HI:      state_next = MPM_ADDR_HI_HOLD;
      MPM_ADDR_HI_HOLD: state_next = MPM_SETUP;
      MPM_SETUP:        if (tmr_expired) state_next = MPM_STROBE;
      MPM_STROBE:       if (tmr_expired) state_next = MPM_HOLD;
      MPM_HOLD:         if (tmr_expired) state_next = MPM_IDLE;
    endcase
  end

  // each timed phase reloads the counter on entry
  always_comb begin
    tmr_load  = (state_next != state_reg);
    tmr_value = '0;
    unique case (state_next)
      MPM_SETUP:  tmr_value = phase_load({2'h0, wait_setup},
                                         MPM_SETUP_BASE); // R16
      MPM_STROBE: tmr_value = phase_load(wait_strobe,
                                         MPM_STROBE_BASE); // R16
      MPM_HOLD:   tmr_value = phase_load({2'h0, wait_hold},
                                         MPM_HOLD_BASE); // R16
      default:    tmr_load = 1'b0;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= MPM_IDLE;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // held address, write data and direction

  // software loads are ignored while an access is in flight
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addr_reg <= MPM_ADDR_RST;
    end else if (clk_en) begin
      if (finish) begin
        addr_reg <= addr_stepped; // R14
      end else if (addr_load && state_reg == MPM_IDLE) begin
        addr_reg <= addr_load_value;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wdata_reg   <= MPM_DATA_RST;
      is_read_reg <= 1'b0;
    end else if (clk_en && go) begin
      wdata_reg   <= write_data;
      is_read_reg <= start_read;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read data: two flops, then capture on the last strobe cycle

  // the strobe base of three covers this two-cycle sampling lag
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_meta_reg <= MPM_DATA_RST;
      pin_sync_reg <= MPM_DATA_RST;
    end else if (clk_en) begin
      pin_meta_reg <= shared_addr_data_pins_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_reg <= MPM_DATA_RST;
    end else if (clk_en) begin
      if (state_reg == MPM_STROBE && tmr_expired && is_read_reg) begin
        rdata_reg <= pin_sync_reg;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // status: busy over the whole access, completion pulses

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      irq_reg  <= 1'b0;
    end else if (clk_en) begin
      if (go) begin
        busy_reg <= 1'b1; // R18
      end else if (finish) begin
        busy_reg <= 1'b0; // R18
      end
      done_reg <= finish;
      irq_reg  <= finish && irq_enable; // R15
    end
  end

  //////////////////////////////////////////////////////////////////////
  // pins, registered from the next state so they line up with it

  assign data_phase = (state_next == MPM_SETUP) ||
                      (state_next == MPM_STROBE) ||
                      (state_next == MPM_HOLD);

  // address byte is held one cycle after its latch closes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pd_out_reg <= MPM_DATA_RST;
      pd_oe_reg  <= 1'b0;
    end else if (clk_en) begin
      unique case (state_next)
        MPM_ADDR_LO, MPM_ADDR_LO_HOLD: begin
          pd_out_reg <= addr_reg[7:0]; // R1
          pd_oe_reg  <= 1'b1;
        end
        MPM_ADDR_HI, MPM_ADDR_HI_HOLD: begin
          // R9
          pd_out_reg <= two_devices ? {2'h0, addr_reg[13:8]}
                                    : {1'b0, addr_reg[14:8]}; // R1
          pd_oe_reg  <= 1'b1;
        end
        MPM_SETUP, MPM_STROBE, MPM_HOLD: begin
          pd_out_reg <= wdata_reg; // R1
          pd_oe_reg  <= !read_next;
        end
        default: begin
          pd_out_reg <= pd_out_reg;
          pd_oe_reg  <= 1'b0;
        end
      endcase
    end
  end

  // latches are transparent while high, so open one cycle each
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lo_latch_reg <= 1'b0;
      hi_latch_reg <= 1'b0;
    end else if (clk_en) begin
      lo_latch_reg <= (state_next == MPM_ADDR_LO); // R2 R6
      hi_latch_reg <= (state_next == MPM_ADDR_HI); // R3 R6
    end
  end

  // selects span the whole access; only the addressed one is active
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cs1_n_reg <= 1'b1;
      cs2_n_reg <= 1'b1;
    end else if (clk_en) begin
      cs2_n_reg <= !((state_next != MPM_IDLE) &&
                     addr_reg[MPM_CS2_BIT]); // R8 R10 R11 R12
      if (two_devices) begin
        cs1_n_reg <= !((state_next != MPM_IDLE) &&
                       addr_reg[MPM_CS1_BIT]); // R10 R11 R12
      end else begin
        cs1_n_reg <= addr_reg[MPM_CS1_BIT]; // R7
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
    end else if (clk_en) begin
      rd_n_reg <= !(state_next == MPM_STROBE && read_next); // R12 R13
      wr_n_reg <= !(state_next == MPM_STROBE && !read_next); // R12 R13
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs

  assign access_address            = addr_reg;
  assign read_data                 = rdata_reg;
  assign busy                      = busy_reg;
  assign done                      = done_reg;
  assign irq                       = irq_reg;
  assign shared_addr_data_pins_out = pd_out_reg;
  assign shared_addr_data_pins_oe  = pd_oe_reg;
  assign low_addr_latch_strobe     = lo_latch_reg;
  assign high_addr_latch_strobe    = hi_latch_reg;
  assign chip_select_one_n         = cs1_n_reg;
  assign chip_select_two_n         = cs2_n_reg;
  assign read_strobe_out_n         = rd_n_reg;
  assign write_strobe_out_n        = wr_n_reg;
  // no byte-select line in these byte-wide setups
  assign byte_select_out           = 1'b0; // R17
  assign byte_select_out_oe        = 1'b0; // R17
  // upper address pins are left to other logic
  assign port_address_pins_out     = '0; // R4
  assign port_address_pins_oe      = '0; // R4

  //////////////////////////////////////////////////////////////////////
  // checks; cycle counts assume clk_en stays high during an access

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_lo_phase;
    low_addr_latch_strobe && shared_addr_data_pins_oe;
  endsequence

  sequence s_hi_phase;
    high_addr_latch_strobe && shared_addr_data_pins_oe;
  endsequence

  a_addr_phase_order: assert property ( // R5
    clk_en && $rose(low_addr_latch_strobe) |->
      s_lo_phase ##1 (!low_addr_latch_strobe && shared_addr_data_pins_oe)
      ##1 s_hi_phase)
    else $error("address phases out of order");

  a_lo_byte_pins: assert property ( // R1
    low_addr_latch_strobe |->
      shared_addr_data_pins_out == access_address[7:0])
    else $error("low address byte not on shared pins");

  a_hi_byte_pins: assert property ( // R9
    high_addr_latch_strobe && two_devices |->
      shared_addr_data_pins_out[7:6] == 2'h0)
    else $error("select bits leaked into high address byte");

  a_latch_exclusive: assert property ( // R6
    !(low_addr_latch_strobe && high_addr_latch_strobe))
    else $error("both address latches open");

  a_upper_released: assert property ( // R4
    port_address_pins_oe == '0)
    else $error("upper address pins driven");

  a_cs_one_bit: assert property ( // R7
    !two_devices && $stable(two_devices) && clk_en
      |=> chip_select_one_n == $past(access_address[14]))
    else $error("select one does not carry address bit 14");

  a_cs_exclusive: assert property ( // R11
    !(!chip_select_one_n && !chip_select_two_n && two_devices))
    else $error("both devices selected");

  a_idle_inactive: assert property ( // R12
    !busy && !done |-> read_strobe_out_n && write_strobe_out_n)
    else $error("strobe active outside an access");

  a_strobe_apart: assert property ( // R13
    read_strobe_out_n || write_strobe_out_n)
    else $error("read and write strobes together");

  a_strobe_width: assert property ( // R16
    clk_en && $fell(read_strobe_out_n) |->
      (!read_strobe_out_n) [*3])
    else $error("read strobe shorter than three cycles");

  a_step_inc: assert property ( // R14
    clk_en && done && $past(step_mode) == MPM_STEP_INC &&
      !$past(two_devices)
      |-> access_address[14:0] == $past(access_address[14:0]) + 15'h0001)
    else $error("address did not step up");

  a_irq_gate: assert property ( // R15
    irq |-> done && $past(irq_enable))
    else $error("interrupt without enabled completion");

  a_busy_span: assert property ( // R18
    clk_en && $rose(busy) |-> busy ##1 busy ##1 busy ##1 busy)
    else $error("busy dropped during address phases");

  a_byte_sel_off: assert property ( // R17
    !byte_select_out_oe)
    else $error("byte select driven");

endmodule : mpm_master

// >>> sim/mpm_mem_model.sv
`timescale 1ns/10ps

// two address latches and byte-wide memory behind the muxed port
module mpm_mem_model
  import mpm_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       two_devices,
  input  wire logic [7:0] pins_out,
  input  wire logic       pins_oe,
  output logic [7:0]      pins_in,
  input  wire logic       lo_stb,
  input  wire logic       hi_stb,
  input  wire logic       cs1_n,
  input  wire logic       cs2_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n
);
  logic [7:0]  mem [0:32767];
  logic [7:0]  lo_q;
  logic [7:0]  hi_q;
  logic [7:0]  last_q = 8'h00;
  logic [14:0] idx;
  logic        sel;

  ////////////////////////////////////////////////////////////////////////////
  // transparent latches pass while enable is high, hold through data phase
  always_latch begin
    if (lo_stb) lo_q <= pins_in;
  end

  // second latch takes the high address byte
  always_latch begin
    if (hi_stb) hi_q <= pins_in;
  end

  // decode; in two-device mode select two picks the upper half of the array
  always_comb begin
    if (two_devices) begin
      sel = !cs1_n || !cs2_n;
      idx = {!cs2_n, hi_q[5:0], lo_q};
    end else begin
      sel = !cs2_n;
      idx = {cs1_n, hi_q[6:0], lo_q};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // released bus shows a changing pattern, so a stale byte never passes
  always_comb begin
    if (pins_oe) pins_in = pins_out;
    else if (sel && !rd_n) pins_in = mem[idx];
    else pins_in = ~last_q;
  end

  // writes land on every strobe cycle; the last one wins
  always_ff @(posedge clock) begin
    last_q <= pins_in;
    if (sel && !wr_n) mem[idx] <= pins_in;
  end

endmodule : mpm_mem_model

// >>> sim/tb.sv
`timescale 1ns/10ps

module tb
  import mpm_pkg::*;
;
  logic        clock = 1'h0;
  logic        rst;
  logic        clk_en;
  logic        port_enable;
  logic        two_devices;
  logic [1:0]  step_mode;
  logic        irq_enable;
  logic [1:0]  wait_setup;
  logic [3:0]  wait_strobe;
  logic [1:0]  wait_hold;
  logic        addr_load;
  logic [15:0] addr_load_value;
  logic        start_read;
  logic        start_write;
  logic [7:0]  write_data;
  logic [15:0] access_address;
  logic [7:0]  read_data;
  logic        busy;
  logic        done;
  logic        irq;
  logic [7:0]  pd_in;
  logic [7:0]  pd_out;
  logic        pd_oe;
  logic        lo_stb;
  logic        hi_stb;
  logic        cs1_n;
  logic        cs2_n;
  logic        rd_n;
  logic        wr_n;
  logic        bs_out;
  logic        bs_oe;
  logic [14:2] pa_out;
  logic [14:2] pa_oe;
  int          error_cnt = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [15:0] atab [4] = '{16'h8123, 16'hFFFF, 16'h8000, 16'hC5A5};
  logic [7:0]  dtab [4] = '{8'hA5, 8'h3C, 8'hFF, 8'h01};
  logic [15:0] btab [3] = '{16'h8012, 16'h4012, 16'h7FFF};

  mpm_master mpm_master_i (
    .clock(clock), .rst(rst), .clk_en(clk_en), .port_enable(port_enable),
    .two_devices(two_devices), .step_mode(step_mode),
    .irq_enable(irq_enable), .wait_setup(wait_setup),
    .wait_strobe(wait_strobe), .wait_hold(wait_hold),
    .addr_load(addr_load), .addr_load_value(addr_load_value),
    .start_read(start_read), .start_write(start_write),
    .write_data(write_data), .access_address(access_address),
    .read_data(read_data), .busy(busy), .done(done), .irq(irq),
    .shared_addr_data_pins_in(pd_in), .shared_addr_data_pins_out(pd_out),
    .shared_addr_data_pins_oe(pd_oe), .low_addr_latch_strobe(lo_stb),
    .high_addr_latch_strobe(hi_stb), .chip_select_one_n(cs1_n),
    .chip_select_two_n(cs2_n), .read_strobe_out_n(rd_n),
    .write_strobe_out_n(wr_n), .byte_select_out(bs_out),
    .byte_select_out_oe(bs_oe), .port_address_pins_out(pa_out),
    .port_address_pins_oe(pa_oe));

  mpm_mem_model mpm_mem_model_i (
    .clock(clock), .two_devices(two_devices), .pins_out(pd_out),
    .pins_oe(pd_oe), .pins_in(pd_in), .lo_stb(lo_stb), .hi_stb(hi_stb),
    .cs1_n(cs1_n), .cs2_n(cs2_n), .rd_n(rd_n), .wr_n(wr_n));

  ////////////////////////////////////////////////////////////////////////////
  // 250 MHz clock and a hang guard well above the few hundred cycles used
  always #2 clock = ~clock;

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    if (error_cnt == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // expected held address after a step; select bits never move
  function automatic logic [15:0] stepped(input logic [15:0] a);
    logic [15:0] d;
    d = (step_mode == MPM_STEP_INC) ? 16'h0001 :
        (step_mode == MPM_STEP_DEC) ? 16'hFFFF : 16'h0000;
    if (two_devices) stepped = {a[15:14], a[13:0] + d[13:0]};
    else stepped = {a[15], a[14:0] + d[14:0]};
  endfunction : stepped

  ////////////////////////////////////////////////////////////////////////////
  // load the held address while idle
  task automatic ld(input logic [15:0] a);
    @(posedge clock);
    addr_load <= 1'h1;
    addr_load_value <= a;
    @(posedge clock);
    addr_load <= 1'h0;
    @(negedge clock);
    chk(access_address, a);
    // select one is registered from the held address a cycle later
    @(negedge clock);
    if (!two_devices) chk(cs1_n, a[14]);
  endtask : ld

  // one access, watched cycle by cycle on the pins
  task automatic xfer(input logic rd, input logic [15:0] a,
                      input logic [7:0] d);
    int          n;
    int          nst;
    int          nlo;
    int          nhi;
    logic [7:0]  hb;
    logic [1:0]  ecs;
    logic [15:0] ea;
    hb = two_devices ? {2'h0, a[13:8]} : {1'h0, a[14:8]};
    ecs = two_devices ? {!a[14], !a[15]} : {a[14], !a[15]};
    ea = stepped(a);
    n = 0;
    nst = 0;
    nlo = 0;
    nhi = 0;
    @(posedge clock);
    start_read <= rd;
    start_write <= !rd;
    write_data <= d;
    @(posedge clock);
    start_read <= 1'h0;
    start_write <= 1'h0;
    while (n < 40) begin
      @(negedge clock);
      n++;
      if (lo_stb) nlo++;
      if (hi_stb) nhi++;
      if (!rd_n || !wr_n) nst++;
      if (lo_stb) chk({pd_oe, pd_out}, {1'h1, a[7:0]});
      if (hi_stb) chk({pd_oe, pd_out}, {1'h1, hb});
      if (!wr_n) chk({pd_oe, pd_out}, {1'h1, d});
      if (!rd_n) chk(pd_oe, 1'h0);
      chk(rd_n | wr_n, 1'h1);
      chk({3'h0, pa_oe}, 16'h0000);
      chk({1'h0, pa_out, bs_oe, bs_out}, 16'h0000);
      if (busy) chk({cs1_n, cs2_n}, ecs);
      if (!done) chk(busy, 1'h1);
      if (done) break;
    end
    chk(16'(n), 16'(10 + wait_setup + wait_strobe + wait_hold));
    chk(16'(nst), 16'(wait_strobe + 3));
    chk(16'({nlo[7:0], nhi[7:0]}), 16'h0101);
    chk({busy, irq}, {1'h0, irq_enable});
    chk({two_devices ? cs1_n : 1'h1, cs2_n}, 2'h3);
    chk(access_address, ea);
    if (rd) chk(read_data, d);
    // completion and interrupt are single-cycle pulses
    @(negedge clock);
    chk({done, irq}, 2'h0);
  endtask : xfer

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst = 1'h1;
    clk_en = 1'h1;
    port_enable = 1'h1;
    two_devices = 1'h0;
    step_mode = MPM_STEP_NONE;
    irq_enable = 1'h0;
    wait_setup = 2'h0;
    wait_strobe = 4'h0;
    wait_hold = 2'h0;
    addr_load = 1'h0;
    addr_load_value = 16'h0000;
    start_read = 1'h0;
    start_write = 1'h0;
    write_data = 8'h00;
    repeat (7) @(posedge clock);
    @(negedge clock);
    chk({busy, done, irq, cs1_n, cs2_n, rd_n, wr_n, lo_stb, hi_stb, pd_oe},
        16'h0078);
    chk({access_address[7:0], read_data}, 16'h0000);
    @(posedge clock);
    rst <= 1'h0;
    // single device: every step mode, setup and strobe waits shortest to longest, hold longest to shortest
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      step_mode <= i[1:0];
      irq_enable <= i[0];
      wait_setup <= i[1:0];
      wait_strobe <= 4'(i * 5);
      wait_hold <= 2'(3 - i);
      ld(atab[i]);
      xfer(1'h0, atab[i], dtab[i]);
      ld(atab[i]);
      xfer(1'h1, atab[i], dtab[i]);
    end
    // starts refused while the port is disabled
    @(posedge clock);
    port_enable <= 1'h0;
    start_write <= 1'h1;
    @(posedge clock);
    start_write <= 1'h0;
    repeat (3) @(negedge clock);
    chk({busy, cs2_n}, 2'h1);
    // a start seen only while the clock enable is low is lost
    @(posedge clock);
    port_enable <= 1'h1;
    clk_en <= 1'h0;
    start_read <= 1'h1;
    @(posedge clock);
    start_read <= 1'h0;
    @(posedge clock);
    clk_en <= 1'h1;
    repeat (3) @(negedge clock);
    chk({busy, rd_n}, 2'h1);
    // two devices: same low address lands in different parts
    @(posedge clock);
    two_devices <= 1'h1;
    step_mode <= MPM_STEP_INC;
    irq_enable <= 1'h1;
    for (int j = 0; j < 3; j++) begin
      ld(btab[j]);
      xfer(1'h0, btab[j], 8'(8'h50 + j));
    end
    for (int j = 0; j < 3; j++) begin
      ld(btab[j]);
      xfer(1'h1, btab[j], 8'(8'h50 + j));
    end
    give_verdict();
  end

endmodule : tb
